// File: design/shr_config_regs.sv
// Configuration register bank for the SAR and magnetic sensing channels.
// Assumes a synchronous byte-wide register port from the serial interface
// and a tuning engine that offers results through the tune_* inputs.
//
// Behaviour
// - Antenna 1 deep threshold is register times long-term average / 256.
// - Antenna 2 proximity threshold is the register value, 0 to 255.
// - Antenna 2 touch threshold is the register value, unscaled, 0 to 255.
// - Antenna 2 deep-touch threshold is register value times four, 0 to 1020.
// - Charge divider select bits 5-4 divide by 2, 4, 8 or 16.
// - Tuning mode bits 1-0: off, partial, semi-partial, full.
// - Partial fixes all multipliers; semi-partial fixes only coarse.
// - Tuning base select bits 7-6 give 75, 100, 150 or 200.
// - Tuning target is the 6-bit field times 32.
// - Compensation is ten bits: low byte plus multiplier register bits 7-6.
// - Coarse multiplier from bits 5-4, fine multiplier from bits 3-0.
`timescale 1ns/1ps

module shr_config_regs (
    input  wire logic        core_clk,        // 250 MHz clock
    input  wire logic        sys_rst,         // Async reset, active high
    input  wire logic [7:0]  reg_addr,        // Register offset
    input  wire logic [7:0]  reg_wdata,       // Write data
    input  wire logic        reg_we,          // Write strobe
    input  wire logic        reg_re,          // Read strobe
    output logic      [7:0]  reg_rdata,       // Read data, registered
    output logic             reg_rvalid,      // Read data valid pulse
    input  wire logic [15:0] long_term_average, // Antenna 1 baseline
    input  wire logic        tune_upd,        // Tuner result strobe
    input  wire logic [9:0]  tune_comp,       // Tuned compensation
    input  wire logic [1:0]  tune_coarse,     // Tuned coarse multiplier
    input  wire logic [3:0]  tune_fine,       // Tuned fine multiplier
    output logic      [15:0] ant1_deep_thr,   // Antenna 1 deep threshold
    output logic      [7:0]  ant2_prox_thr,   // Antenna 2 prox threshold
    output logic      [7:0]  ant2_touch_thr,  // Antenna 2 touch threshold
    output logic      [9:0]  ant2_deep_thr,   // Antenna 2 deep threshold
    output logic      [1:0]  charge_divider_sel, // Divider code
    output logic             charge_tick,     // Charge frequency pulse
    output logic      [1:0]  auto_tune_mode,  // Tuning mode code
    output logic             tune_enable,     // Tuning active
    output logic             coarse_fixed,    // Coarse multiplier frozen
    output logic             fine_fixed,      // Fine multiplier frozen
    output logic      [7:0]  tune_base,       // Tuning base value
    output logic      [10:0] tune_target,     // Tuning target value
    output logic      [9:0]  mag_comp,        // Compensation value
    output logic      [1:0]  mag_coarse,      // Coarse multiplier
    output logic      [3:0]  mag_fine         // Fine multiplier
);

    shr_pkg::shr_state_t st_r;
    shr_pkg::shr_state_t st_nxt;

    logic [1:0] mode_w;
    logic [1:0] sel_w;
    logic [3:0] div_term;
    logic [23:0] ant1_prod;

    assign mode_w = st_r.mag0[shr_pkg::MODE_LSB +: 2];
    assign sel_w  = st_r.mag0[shr_pkg::CHG_SEL_LSB +: 2];

    // Divider terminal count: ratio 2, 4, 8, 16 minus one
    always_comb begin
        case (sel_w)
            2'b00:   div_term = 4'h1;
            2'b01:   div_term = 4'h3;
            2'b10:   div_term = 4'h7;
            default: div_term = 4'hF;
        endcase
    end

    // Next state: host access, tuner writeback, charge divider
    always_comb begin
        st_nxt        = st_r;
        st_nxt.rvalid = reg_re;
        // Tuner results land only in fields the mode leaves free
        if (tune_upd && (mode_w != shr_pkg::TUNE_OFF)) begin
            st_nxt.comp_lo = tune_comp[7:0];
            st_nxt.mult[shr_pkg::COMP_HI_LSB +: 2] = tune_comp[9:8];
            if (mode_w == shr_pkg::TUNE_FULL) begin
                st_nxt.mult[shr_pkg::COARSE_LSB +: 2] = tune_coarse;
            end
            if (mode_w != shr_pkg::TUNE_PART) begin
                st_nxt.mult[shr_pkg::FINE_LSB +: 4] = tune_fine;
            end
        end
        // Host write takes priority over a tuner result
        if (reg_we) begin
            case (reg_addr)
                shr_pkg::ANT1_DEEP_OFS:  st_nxt.ant1_deep  = reg_wdata;
                shr_pkg::ANT2_PROX_OFS:  st_nxt.ant2_prox  = reg_wdata;
                shr_pkg::ANT2_TOUCH_OFS: st_nxt.ant2_touch = reg_wdata;
                shr_pkg::ANT2_DEEP_OFS:  st_nxt.ant2_deep  = reg_wdata;
                shr_pkg::MAG0_OFS:
                    st_nxt.mag0 = reg_wdata & shr_pkg::MAG0_WMASK;
                shr_pkg::MAG1_OFS:       st_nxt.mag1       = reg_wdata;
                shr_pkg::COMP_LO_OFS:    st_nxt.comp_lo    = reg_wdata;
                shr_pkg::MULT_OFS:       st_nxt.mult       = reg_wdata;
                default: ;
            endcase
        end
        // Read data captured from current contents
        if (reg_re) begin
            case (reg_addr)
                shr_pkg::ANT1_DEEP_OFS:  st_nxt.rdata = st_r.ant1_deep;
                shr_pkg::ANT2_PROX_OFS:  st_nxt.rdata = st_r.ant2_prox;
                shr_pkg::ANT2_TOUCH_OFS: st_nxt.rdata = st_r.ant2_touch;
                shr_pkg::ANT2_DEEP_OFS:  st_nxt.rdata = st_r.ant2_deep;
                shr_pkg::MAG0_OFS:       st_nxt.rdata = st_r.mag0;
                shr_pkg::MAG1_OFS:       st_nxt.rdata = st_r.mag1;
                shr_pkg::COMP_LO_OFS:    st_nxt.rdata = st_r.comp_lo;
                shr_pkg::MULT_OFS:       st_nxt.rdata = st_r.mult;
                default: st_nxt.rdata = shr_pkg::UNMAPPED_READ;
            endcase
        end
        // Charge frequency divider
        if (st_r.div_cnt >= div_term) begin
            st_nxt.div_cnt     = 4'h0;
            st_nxt.charge_tick = 1'b1;
        end else begin
            st_nxt.div_cnt     = st_r.div_cnt + 4'h1;
            st_nxt.charge_tick = 1'b0;
        end
    end

    // State register
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_r.ant1_deep   <= shr_pkg::THR_RST;
            st_r.ant2_prox   <= shr_pkg::THR_RST;
            st_r.ant2_touch  <= shr_pkg::THR_RST;
            st_r.ant2_deep   <= shr_pkg::THR_RST;
            st_r.mag0        <= shr_pkg::MAG0_RST;
            st_r.mag1        <= shr_pkg::MAG1_RST;
            st_r.comp_lo     <= shr_pkg::COMP_RST;
            st_r.mult        <= shr_pkg::COMP_RST;
            st_r.rdata       <= shr_pkg::UNMAPPED_READ;
            st_r.rvalid      <= 1'b0;
            st_r.div_cnt     <= 4'h0;
            st_r.charge_tick <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // Threshold outputs
    assign ant1_prod      = st_r.ant1_deep * long_term_average;
    assign ant1_deep_thr  = ant1_prod[shr_pkg::LTA_SHIFT +: 16];
    assign ant2_prox_thr  = st_r.ant2_prox;
    assign ant2_touch_thr = st_r.ant2_touch;
    assign ant2_deep_thr  = {st_r.ant2_deep, 2'b00};

    // Magnetic channel settings
    assign charge_divider_sel = sel_w;
    assign charge_tick        = st_r.charge_tick;
    assign auto_tune_mode     = mode_w;
    assign tune_enable        = (mode_w != shr_pkg::TUNE_OFF);
    assign coarse_fixed       = (mode_w == shr_pkg::TUNE_PART) ||
                                (mode_w == shr_pkg::TUNE_SEMI);
    assign fine_fixed         = (mode_w == shr_pkg::TUNE_PART);
    assign tune_target = {st_r.mag1[shr_pkg::TARGET_LSB +: 6],
                          5'h00};
    assign mag_comp    = {st_r.mult[shr_pkg::COMP_HI_LSB +: 2],
                          st_r.comp_lo};
    assign mag_coarse  = st_r.mult[shr_pkg::COARSE_LSB +: 2];
    assign mag_fine    = st_r.mult[shr_pkg::FINE_LSB +: 4];
    assign reg_rdata   = st_r.rdata;
    assign reg_rvalid  = st_r.rvalid;

    // Tuning base lookup
    always_comb begin
        case (st_r.mag1[shr_pkg::BASE_LSB +: 2])
            2'b00:   tune_base = shr_pkg::BASE_0;
            2'b01:   tune_base = shr_pkg::BASE_1;
            2'b10:   tune_base = shr_pkg::BASE_2;
            default: tune_base = shr_pkg::BASE_3;
        endcase
    end

    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    sequence s_tick_fast;
        charge_tick && (charge_divider_sel == 2'b00);
    endsequence

    sequence s_tick_again;
        !charge_tick ##1 charge_tick;
    endsequence

    a_ant1_deep_scale: assert property (
        ant1_deep_thr == 16'((32'(st_r.ant1_deep) *
        32'(long_term_average)) >> 8))
        else $error("Antenna 1 deep threshold scaling wrong");

    a_ant2_prox_write: assert property (
        reg_we && reg_addr == 8'h81 |=> ant2_prox_thr == $past(reg_wdata))
        else $error("Antenna 2 prox threshold not taken directly");

    a_ant2_touch_write: assert property (
        reg_we && reg_addr == 8'h82 |=> ant2_touch_thr == $past(reg_wdata))
        else $error("Antenna 2 touch threshold not taken directly");

    a_ant2_deep_write: assert property (
        reg_we && reg_addr == 8'h83
        |=> ant2_deep_thr == {$past(reg_wdata), 2'b00})
        else $error("Antenna 2 deep threshold not times four");

    a_charge_div_two: assert property (
        s_tick_fast ##1 (charge_divider_sel == 2'b00) |-> s_tick_again)
        else $error("Charge divide by two period wrong");

    a_tune_mode_off: assert property (
        (auto_tune_mode == 2'b00) |-> !tune_enable && !coarse_fixed)
        else $error("Tuning off decoded wrongly");

    a_partial_hold: assert property (
        tune_upd && auto_tune_mode == 2'b01 && !reg_we
        |=> mag_coarse == $past(mag_coarse) && mag_fine == $past(mag_fine))
        else $error("Partial tuning changed a multiplier");

    a_semi_hold: assert property (
        tune_upd && auto_tune_mode == 2'b10 && !reg_we
        |=> mag_coarse == $past(mag_coarse) && mag_fine == $past(tune_fine))
        else $error("Semi-partial tuning handled multipliers wrongly");

    a_base_map: assert property (
        reg_we && reg_addr == 8'h91 && reg_wdata[7:6] == 2'b10
        |=> tune_base == 8'd150)
        else $error("Tuning base mapping wrong");

    a_target_scale: assert property (
        reg_we && reg_addr == 8'h91
        |=> tune_target == 11'($past(reg_wdata[5:0]) * 32))
        else $error("Tuning target scaling wrong");

    a_comp_join: assert property (
        reg_we && reg_addr == 8'h93 |=> mag_comp[9:8] == $past(reg_wdata[7:6])
        && mag_coarse == $past(reg_wdata[5:4]))
        else $error("Compensation or multiplier fields misplaced");

    a_tune_update: assert property (
        tune_upd && auto_tune_mode == 2'b11 && !reg_we
        |=> mag_comp == $past(tune_comp) && mag_coarse == $past(tune_coarse))
        else $error("Full tuning result not written back");

    a_read_return: assert property (
        reg_re && !reg_we && reg_addr == 8'h90
        |=> reg_rvalid && reg_rdata == {2'b00, $past(charge_divider_sel),
            2'b00, $past(auto_tune_mode)})
        else $error("Settings read-back wrong");

    // Charge pulse spacing, settings fields, tuner results ignored while off, and read path
    sequence s_div4_window;
        charge_tick && (charge_divider_sel == 2'b01)
        ##1 (charge_divider_sel == 2'b01) [*3];
    endsequence

    sequence s_div8_window;
        charge_tick && (charge_divider_sel == 2'b10)
        ##1 (charge_divider_sel == 2'b10) [*7];
    endsequence

    a_charge_div_four: assert property (
        s_div4_window |=> charge_tick && !$past(charge_tick)
        && !$past(charge_tick, 2) && !$past(charge_tick, 3))
        else $error("Charge divide by four period wrong");

    a_charge_div_eight: assert property (
        s_div8_window |=> charge_tick)
        else $error("Charge divide by eight period wrong");

    a_charge_no_early: assert property (
        charge_tick && (charge_divider_sel != 2'b00) |=> !charge_tick)
        else $error("Charge pulse too soon for slow divider");

    a_settings_write: assert property (
        reg_we && reg_addr == 8'h90
        |=> charge_divider_sel == $past(reg_wdata[5:4])
        && auto_tune_mode == $past(reg_wdata[1:0]))
        else $error("Settings fields misplaced");

    a_mode_off_ignore: assert property (
        tune_upd && auto_tune_mode == 2'b00 && !reg_we
        |=> mag_comp == $past(mag_comp) && mag_coarse == $past(mag_coarse)
        && mag_fine == $past(mag_fine))
        else $error("Tuner result taken while tuning off");

    a_read_deep: assert property (
        reg_re && !reg_we && reg_addr == 8'h83
        |=> {reg_rdata, 2'b00} == $past(ant2_deep_thr))
        else $error("Deep threshold read-back wrong");

    a_read_unmapped: assert property (
        reg_re && !(reg_addr inside {8'h63, [8'h81:8'h83], [8'h90:8'h93]})
        |=> reg_rvalid && reg_rdata == 8'h00)
        else $error("Unmapped read not zero");

    a_rvalid_pulse: assert property (
        reg_rvalid == $past(reg_re))
        else $error("Read valid not one cycle after strobe");

endmodule

// File: design/shr_pkg.sv
// Constants and state type for the sensor configuration register bank.
// Assumes a byte-wide register port driven by the serial interface logic.
package shr_pkg;

    // Register offsets
    localparam logic [7:0] ANT1_DEEP_OFS  = 8'h63;
    localparam logic [7:0] ANT2_PROX_OFS  = 8'h81;
    localparam logic [7:0] ANT2_TOUCH_OFS = 8'h82;
    localparam logic [7:0] ANT2_DEEP_OFS  = 8'h83;
    localparam logic [7:0] MAG0_OFS       = 8'h90;
    localparam logic [7:0] MAG1_OFS       = 8'h91;
    localparam logic [7:0] COMP_LO_OFS    = 8'h92;
    localparam logic [7:0] MULT_OFS       = 8'h93;

    // Values after reset
    localparam logic [7:0] MAG0_RST       = 8'h03;
    localparam logic [7:0] MAG1_RST       = 8'h50;
    localparam logic [7:0] THR_RST        = 8'h00;
    localparam logic [7:0] COMP_RST       = 8'h00;
    localparam logic [7:0] UNMAPPED_READ  = 8'h00;

    // Field positions and masks
    localparam int CHG_SEL_LSB  = 4;
    localparam int MODE_LSB     = 0;
    localparam int BASE_LSB     = 6;
    localparam int TARGET_LSB   = 0;
    localparam int COMP_HI_LSB  = 6;
    localparam int COARSE_LSB   = 4;
    localparam int FINE_LSB     = 0;
    localparam logic [7:0] MAG0_WMASK = 8'h33;

    // Scaling
    localparam int LTA_SHIFT    = 8;
    localparam int DEEP2_SHIFT  = 2;
    localparam int TARGET_SHIFT = 5;

    // Tuning base values
    localparam logic [7:0] BASE_0 = 8'h4B;
    localparam logic [7:0] BASE_1 = 8'h64;
    localparam logic [7:0] BASE_2 = 8'h96;
    localparam logic [7:0] BASE_3 = 8'hC8;

    // Automatic tuning modes
    localparam logic [1:0] TUNE_OFF  = 2'b00;
    localparam logic [1:0] TUNE_PART = 2'b01;
    localparam logic [1:0] TUNE_SEMI = 2'b10;
    localparam logic [1:0] TUNE_FULL = 2'b11;

    typedef struct packed {
        logic [7:0] ant1_deep;
        logic [7:0] ant2_prox;
        logic [7:0] ant2_touch;
        logic [7:0] ant2_deep;
        logic [7:0] mag0;
        logic [7:0] mag1;
        logic [7:0] comp_lo;
        logic [7:0] mult;
        logic [7:0] rdata;
        logic       rvalid;
        logic [3:0] div_cnt;
        logic       charge_tick;
    } shr_state_t;

endpackage

// File: test/sar_hall_config_regs_bench.sv
// Self-checking bench for the sensor configuration register bank.
// Assumes the host model drives the register port.
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_fail++; \
    $display("unexpected at %0t: got %0h want %0h", $time, g, e); end end

module sar_hall_config_regs_bench;
    logic        core_clk, sys_rst, reg_we, reg_re, reg_rvalid, tune_upd;
    logic [7:0]  reg_addr, reg_wdata, reg_rdata, ant2_prox_thr;
    logic [7:0]  ant2_touch_thr, tune_base;
    logic [15:0] long_term_average, ant1_deep_thr;
    logic [9:0]  tune_comp, ant2_deep_thr, mag_comp;
    logic [1:0]  tune_coarse, charge_divider_sel, auto_tune_mode, mag_coarse;
    logic [3:0]  tune_fine, mag_fine;
    logic        charge_tick, tune_enable, coarse_fixed, fine_fixed;
    logic [10:0] tune_target;
    int          n_fail, checks, cyc, rm[256];
    logic [7:0]  al[8] = '{8'h63, 8'h81, 8'h82, 8'h83,
                           8'h90, 8'h91, 8'h92, 8'h93};
    int          bt[4] = '{75, 100, 150, 200};

    shr_config_regs dut (
        .core_clk           (core_clk),
        .sys_rst            (sys_rst),
        .reg_addr           (reg_addr),
        .reg_wdata          (reg_wdata),
        .reg_we             (reg_we),
        .reg_re             (reg_re),
        .reg_rdata          (reg_rdata),
        .reg_rvalid         (reg_rvalid),
        .long_term_average  (long_term_average),
        .tune_upd           (tune_upd),
        .tune_comp          (tune_comp),
        .tune_coarse        (tune_coarse),
        .tune_fine          (tune_fine),
        .ant1_deep_thr      (ant1_deep_thr),
        .ant2_prox_thr      (ant2_prox_thr),
        .ant2_touch_thr     (ant2_touch_thr),
        .ant2_deep_thr      (ant2_deep_thr),
        .charge_divider_sel (charge_divider_sel),
        .charge_tick        (charge_tick),
        .auto_tune_mode     (auto_tune_mode),
        .tune_enable        (tune_enable),
        .coarse_fixed       (coarse_fixed),
        .fine_fixed         (fine_fixed),
        .tune_base          (tune_base),
        .tune_target        (tune_target),
        .mag_comp           (mag_comp),
        .mag_coarse         (mag_coarse),
        .mag_fine           (mag_fine)
    );
    shr_host_model host (
        .core_clk   (core_clk),
        .reg_addr   (reg_addr),
        .reg_wdata  (reg_wdata),
        .reg_we     (reg_we),
        .reg_re     (reg_re),
        .reg_rdata  (reg_rdata),
        .reg_rvalid (reg_rvalid)
    );

    // Clock and hang guard
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 3000) begin  // Tests need about 900 cycles
            n_fail++;
            finish_test;
        end
    end

    task automatic finish_test;
        if (n_fail == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // Write through the host and track the reference image
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        host.wr(a, d);
        if (a inside {8'h63, [8'h81:8'h83], [8'h90:8'h93]})
            rm[a] = (a == 8'h90) ? (d & 8'h33) : d;
    endtask

    task automatic rdchk(input logic [7:0] a);
        logic [7:0] v;
        host.rd(a, v);
        `CHK(v, 8'(rm[a]))
    endtask

    // Compare every decoded output with the reference image
    task automatic chk_all;
        int m0, m1, mu, md;
        m0 = rm[8'h90];
        m1 = rm[8'h91];
        mu = rm[8'h93];
        md = m0 & 3;
        `CHK(ant1_deep_thr, 16'((rm[8'h63] * long_term_average) >> 8))
        `CHK(ant2_prox_thr, 8'(rm[8'h81]))
        `CHK(ant2_touch_thr, 8'(rm[8'h82]))
        `CHK(ant2_deep_thr, 10'(rm[8'h83] * 4))
        `CHK(charge_divider_sel, 2'(m0 >> 4))
        `CHK(auto_tune_mode, 2'(md))
        `CHK({tune_enable, coarse_fixed, fine_fixed},
             {md != 0, md == 1 || md == 2, md == 1})
        `CHK(tune_base, 8'(bt[m1 >> 6]))
        `CHK(tune_target, 11'((m1 & 63) * 32))
        `CHK(mag_comp, 10'((mu >> 6) * 256 + rm[8'h92]))
        `CHK({mag_coarse, mag_fine}, 6'(mu & 63))
    endtask

    task automatic tick_gap(output int n);
        n = 0;
        do begin
            @(negedge core_clk);
            n++;
        end while (charge_tick !== 1'b1 && n < 64);
    endtask

    // Main sequence
    initial begin
        int n;
        logic [7:0] mu;
        void'($urandom(40101));
        sys_rst = 1'b1;
        tune_upd = 1'b0;
        tune_comp = 10'h000;
        tune_coarse = 2'h0;
        tune_fine = 4'h0;
        long_term_average = 16'h1234;
        rm[8'h90] = 8'h03;
        rm[8'h91] = 8'h50;
        repeat (8) @(posedge core_clk);
        sys_rst <= 1'b0;
        // Reset values, plus one unmapped place
        foreach (al[i]) rdchk(al[i]);
        rdchk(8'h00);
        @(negedge core_clk);
        chk_all;
        // Random contents, decoded outputs and readback
        repeat (20) begin
            foreach (al[i]) wr(al[i], 8'($urandom));
            wr(8'hA5, 8'($urandom));
            @(posedge core_clk);
            long_term_average <= 16'($urandom);
            @(negedge core_clk);
            chk_all;
            foreach (al[i]) rdchk(al[i]);
            rdchk(8'hA5);
        end
        // Reset in mid-run brings back the values after reset
        @(posedge core_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        foreach (rm[i]) rm[i] = 0;
        rm[8'h90] = 8'h03;
        rm[8'h91] = 8'h50;
        foreach (al[i]) rdchk(al[i]);
        @(negedge core_clk);
        chk_all;
        // Charge divider periods for each code
        for (int c = 0; c < 4; c++) begin
            wr(8'h90, 8'(c << 4));
            tick_gap(n);
            tick_gap(n);
            `CHK(n, 2 << c)
        end
        // Tuner results in every mode
        for (int m = 0; m < 4; m++) begin
            wr(8'h90, 8'(m));
            wr(8'h92, 8'h5A);
            wr(8'h93, 8'h96);
            @(posedge core_clk);
            tune_comp <= 10'($urandom);
            tune_coarse <= 2'($urandom);
            tune_fine <= 4'($urandom);
            tune_upd <= 1'b1;
            @(posedge core_clk);
            tune_upd <= 1'b0;
            mu = 8'(rm[8'h93]);
            if (m != 0) begin
                rm[8'h92] = tune_comp[7:0];
                rm[8'h93] = {tune_comp[9:8],
                             (m == 3) ? tune_coarse : mu[5:4],
                             (m >= 2) ? tune_fine : mu[3:0]};
            end
            @(negedge core_clk);
            chk_all;
            rdchk(8'h92);
            rdchk(8'h93);
        end
        finish_test;
    end
endmodule

// File: test/shr_host_model.sv
// Host side of the register port: issues byte writes and reads.
// Assumes the bank answers a read with a reg_rvalid pulse soon after.
`timescale 1ns/1ps

module shr_host_model (
    input  wire logic       core_clk,   // Bus clock
    output logic      [7:0] reg_addr,   // Register offset
    output logic      [7:0] reg_wdata,  // Write data
    output logic            reg_we,     // Write strobe
    output logic            reg_re,     // Read strobe
    input  wire logic [7:0] reg_rdata,  // Read data
    input  wire logic       reg_rvalid  // Read data valid
);
    // Idle bus at time zero
    initial begin
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
        reg_we    = 1'b0;
        reg_re    = 1'b0;
    end

    // One write; idle bus shows inverted values, never stale ones
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_we    <= 1'b1;
        @(posedge core_clk);
        reg_we    <= 1'b0;
        reg_addr  <= ~a;
        reg_wdata <= ~d;
    endtask

    // One read; waits a bounded time for the valid pulse
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        reg_addr <= a;
        reg_re   <= 1'b1;
        @(posedge core_clk);
        reg_re   <= 1'b0;
        reg_addr <= ~a;
        do begin
            @(negedge core_clk);
            n++;
        end while (reg_rvalid !== 1'b1 && n < 8);
        d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hxx;
    endtask
endmodule
